// ### cce_pkg.sv
// Constants and types for the call and clear execution block
package cce_pkg;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned INSN_W  = 12;
  localparam int unsigned PCNT_W  = 11;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned FADDR_W = 5;

  localparam logic [3:0]  CALL_OPC     = 4'h9;
  localparam logic [11:0] CLR_WREG_WORD = 12'h040;
  localparam logic [6:0]  CLR_FREG_OPC  = 7'h03;
  localparam int unsigned STAT_PAGE_LO = 5;
  localparam int unsigned STAT_PAGE_HI = 6;
  localparam int unsigned STAT_ZERO    = 2;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;
  localparam logic [10:0] PCNT_RESET   = 11'h7FF;

  typedef enum logic [3:0] {
    CCE_OP_NONE = 4'b0001,
    CCE_OP_CALL = 4'b0010,
    CCE_OP_CLR_WREG = 4'b0100,
    CCE_OP_CLR_FREG = 4'b1000
  } cce_op_t;
endpackage : cce_pkg

// ### cce_decode.sv
// Combinational instruction word decoder
module cce_decode
  import cce_pkg::*;
(
  input  wire logic [cce_pkg::INSN_W-1:0] insn_in,
  output cce_pkg::cce_op_t               op_out
);
  timeunit 1ns;
  timeprecision 100ps;
  always_comb begin
    if (insn_in[11:8] == CALL_OPC) begin
      op_out = CCE_OP_CALL;
    end else if (insn_in == CLR_WREG_WORD) begin
      op_out = CCE_OP_CLR_WREG;
    end else if (insn_in[11:5] == CLR_FREG_OPC) begin
      op_out = CCE_OP_CLR_FREG;
    end else begin
      op_out = CCE_OP_NONE;
    end
  end
endmodule : cce_decode

// ### cce_exec.sv
// Execution of call, working-register clear and file-register clear
module cce_exec
  import cce_pkg::*;
(
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        insn_valid_in,
  input  wire logic [cce_pkg::INSN_W-1:0]  insn_in,
  input  wire logic [cce_pkg::DATA_W-1:0]  status_in,
  output logic                             busy_out,
  output logic [cce_pkg::PCNT_W-1:0]       program_counter_out,
  output logic                             push_out,
  output logic [cce_pkg::PCNT_W-1:0]       stack_top_out,
  output logic                             wreg_we_out,
  output logic [cce_pkg::DATA_W-1:0]       wreg_data_out,
  output logic                             freg_we_out,
  output logic [cce_pkg::FADDR_W-1:0]      freg_addr_out,
  output logic [cce_pkg::DATA_W-1:0]       freg_data_out,
  output logic                             zero_set_out
);
  timeunit 1ns;
  timeprecision 100ps;
  import cce_pkg::*;

  typedef struct packed {
    logic               busy;
    logic [PCNT_W-1:0]  pcnt;
    logic               push;
    logic [PCNT_W-1:0]  top;
    logic               wwe;
    logic               fwe;
    logic [FADDR_W-1:0] faddr;
    logic               zset;
  } cce_state_t;

  cce_state_t s_q;
  cce_state_t s_d;
  cce_op_t    op;

  // Return address and straight-line advance share one wrapping increment
  function automatic logic [PCNT_W-1:0] pcnt_incr(
    input logic [PCNT_W-1:0] value
  );
    return PCNT_W'(value + 1'b1);
  endfunction : pcnt_incr

  cce_decode u_dec (
    .insn_in (insn_in),
    .op_out  (op)
  );

  always_comb begin
    s_d      = s_q;
    s_d.push = 1'b0;
    s_d.wwe  = 1'b0;
    s_d.fwe  = 1'b0;
    s_d.zset = 1'b0;
    if (s_q.busy) begin
      // Second call cycle executes the fetch slot as a bubble
      s_d.busy = 1'b0;
    end else if (insn_valid_in) begin
      s_d.pcnt = pcnt_incr(s_q.pcnt);
      unique case (op)
        CCE_OP_CALL: begin
          s_d.push = 1'b1;
          s_d.top  = pcnt_incr(s_q.pcnt);
          s_d.pcnt = {status_in[STAT_PAGE_HI:STAT_PAGE_LO],
                      1'b0,
                      insn_in[7:0]};
          s_d.busy = 1'b1;
        end
        CCE_OP_CLR_WREG: begin
          s_d.wwe  = 1'b1;
          s_d.zset = 1'b1;
        end
        CCE_OP_CLR_FREG: begin
          s_d.fwe   = 1'b1;
          s_d.faddr = insn_in[FADDR_W-1:0];
          s_d.zset  = 1'b1;
        end
        CCE_OP_NONE: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '{busy: 1'b0, pcnt: PCNT_RESET, push: 1'b0, top: '0,
               wwe: 1'b0, fwe: 1'b0, faddr: '0, zset: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy_out            = s_q.busy;
  assign program_counter_out = s_q.pcnt;
  assign push_out            = s_q.push;
  assign stack_top_out       = s_q.top;
  assign wreg_we_out         = s_q.wwe;
  assign wreg_data_out       = ZERO_BYTE;
  assign freg_we_out         = s_q.fwe;
  assign freg_addr_out       = s_q.faddr;
  assign freg_data_out       = ZERO_BYTE;
  assign zero_set_out        = s_q.zset;
endmodule : cce_exec

// ### cce_exec_checker.sv
// Assertion checker for the call and clear execution block
module cce_exec_checker (
  input wire logic        sys_clk_in, rst_n_in, insn_valid_in, busy_out,
  input wire logic        push_out, wreg_we_out, freg_we_out, zero_set_out,
  input wire logic [11:0] insn_in,
  input wire logic [7:0]  status_in,
  input wire logic [10:0] program_counter_out, stack_top_out,
  input wire logic [4:0]  freg_addr_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire tk = insn_valid_in && !busy_out;
  wire cl = tk && insn_in[11:8] == 4'h9;
  wire cw = tk && insn_in == 12'h040;
  wire cf = tk && insn_in[11:5] == 7'h03;
  a_call_push: assert property (cl |=> push_out && stack_top_out ==
    $past(program_counter_out) + 11'h001) else $error("push");
  a_call_low: assert property (cl |=>
    program_counter_out[7:0] == $past(insn_in[7:0])) else $error("low");
  a_call_page: assert property (cl |=>
    program_counter_out[10:9] == $past(status_in[6:5])) else $error("page");
  a_call_bit8: assert property (cl |=>
    !program_counter_out[8]) else $error("bit8");
  a_call_two: assert property (cl |=> busy_out && !zero_set_out
    ##1 !busy_out && !push_out) else $error("two");
  a_wreg_clear: assert property (cw |=> wreg_we_out &&
    program_counter_out == $past(program_counter_out) + 11'h001)
    else $error("w");
  a_wreg_zero: assert property (cw |=> zero_set_out) else
    $error("wz");
  a_freg_clear: assert property (cf |=> freg_we_out && zero_set_out
    && freg_addr_out == $past(insn_in[4:0])) else $error("f");
  c_call: cover property (cl);
  c_wreg_clear: cover property (cw);
  c_freg_clear: cover property (cf);
  c_call_refused: cover property (busy_out && insn_valid_in);
endmodule : cce_exec_checker
bind cce_exec cce_exec_checker u_chk (.*);

// ### testbench.sv
// Random bench comparing the execution block with a model
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 0, rst_n_in = 0, insn_valid_in = 0, busy_out, push_out;
  logic wreg_we_out, freg_we_out, zero_set_out, mb, mu, mw, mf, mz;
  logic [11:0] insn_in = 12'h000;
  logic [7:0] status_in = 8'h00, wreg_data_out, freg_data_out;
  logic [10:0] program_counter_out, stack_top_out, mp, ms;
  logic [4:0] freg_addr_out, ma;
  logic [31:0] r;
  int n_fail = 0, n_checks = 0, cyc = 0;
  wire [47:0] g = {program_counter_out, stack_top_out, busy_out, push_out,
    wreg_we_out, freg_we_out, zero_set_out, freg_addr_out, wreg_data_out,
    freg_data_out};
  wire [47:0] e = {mp, ms, mb, mu, mw, mf, mz, ma, 16'h0000};
  cce_exec dut (.*);
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial forever #12.5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in or negedge rst_n_in)
    if (!rst_n_in) {mp, ms, mb, mu, mw, mf, mz, ma} = {11'h7FF, 21'h0};
    else begin
      {mu, mw, mf, mz} = 4'h0;
      if (mb) mb = 0;
      else if (insn_valid_in && insn_in[11:8] == 4'h9) begin
        {mu, mb, ms} = {2'b11, mp + 11'h001};
        mp = {status_in[6:5], 1'b0, insn_in[7:0]};
      end else if (insn_valid_in) begin
        mp = mp + 11'h001;
        if (insn_in == 12'h040) {mw, mz} = 2'b11;
        if (insn_in[11:5] == 7'h03) begin
          {mf, mz, ma} = {2'b11, insn_in[4:0]};
        end
      end
    end
  always @(negedge sys_clk_in) if (rst_n_in) begin
    n_checks++;
    if (e[47:26] !== g[47:26]) begin
      $display("[ERR] pc_and_top exp %h seen %h", e[47:26], g[47:26]);
      n_fail++;
    end
    n_checks++;
    if (e[25:0] !== g[25:0]) begin
      $display("[ERR] strobes exp %h seen %h", e[25:0], g[25:0]);
      n_fail++;
    end
  end
  always @(posedge sys_clk_in) if (++cyc > 4000) begin
    n_fail++;
    end_of_test;
  end
  // Half the draws calls and clears, half random words, with calls often back to back to hit busy
  initial begin
    r = $urandom(31773);
    repeat (2) @(posedge sys_clk_in);
    rst_n_in <= 1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk_in);
      r = $urandom;
      rst_n_in <= (i != 1500);
      insn_valid_in <= r[0] | r[1];
      status_in <= r[31:24];
      case (r[4:2])
        0, 1: insn_in <= {4'h9, r[15:8]};
        2: insn_in <= 12'h040;
        3: insn_in <= {7'h03, r[20:16]};
        default: insn_in <= r[31:20];
      endcase
    end
    end_of_test;
  end
endmodule : testbench
